// ==== nim_input_event_counter.sv ====
// four logic inputs, two edge counters, default configuration handling
// ---------------------------------------------------------------
// Notes on behaviour
// - four input levels are readable at any time, regardless of counting
// - inputs 1 and 3 count rising or falling edges as selected
// - counters clear by command or by input 2 / input 4 reset
// - external reset only acts when its per-counter enable is set
// - external reset is active high level, holds counter at zero
// - a level value of one means high, zero means low
// - the default button reloads the whole default configuration
// - defaults apply at power-up and by command too
// - defaults indicator on when applied, off on any setting change
// - each button press raises a host event flag
// ---------------------------------------------------------------
`timescale 1ns/1ps
module nim_input_event_counter (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic [3:0] NIM_IN,
  input wire logic DEFAULT_BTN,
  input wire logic [nim_in_pkg::ADDR_W-1:0] ADDR,
  input wire logic [nim_in_pkg::DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [nim_in_pkg::DATA_W-1:0] RDATA,
  output logic DEFAULTS_LED,
  output logic BTN_EVENT
);
  import nim_in_pkg::*;

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  logic [3:0] lvl;
  logic btn_lvl;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      nim_in_sync u_sync (
        .CLK(CLK),
        .SYS_RST(SYS_RST),
        .d(NIM_IN[gi]),
        .q(lvl[gi])
      );
    end
  endgenerate
  nim_in_sync u_btn_sync (
    .CLK(CLK),
    .SYS_RST(SYS_RST),
    .d(DEFAULT_BTN),
    .q(btn_lvl)
  );

  // ---------------------------------------------------------------
  // edge detection
  // ---------------------------------------------------------------
  logic [3:0] lvl_d;
  logic btn_d;
  logic btn_press;
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      lvl_d <= 4'h0;
      btn_d <= 1'b0;
    end else begin
      lvl_d <= lvl;
      btn_d <= btn_lvl;
    end
  end
  assign btn_press = btn_lvl & ~btn_d;

  // ---------------------------------------------------------------
  // register port decode
  // ---------------------------------------------------------------
  logic wr_cfg1;
  logic wr_cfg3;
  logic wr_cmd;
  logic apply_default;
  assign wr_cfg1 = WR && (ADDR == OFS_CFG1);
  assign wr_cfg3 = WR && (ADDR == OFS_CFG3);
  assign wr_cmd = WR && (ADDR == OFS_CMD);
  // the button and the command both reload the defaults
  assign apply_default = btn_press ||
    (wr_cmd && WDATA[CMD_DEFAULT]);

  // ---------------------------------------------------------------
  // counter configuration
  // ---------------------------------------------------------------
  logic [2:0] cfg1;
  logic [2:0] cfg3;
  // reset gives the default set, as at power-up
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      cfg1 <= CFG_DEFAULT;
    end else if (apply_default) begin
      cfg1 <= CFG_DEFAULT;
    end else if (wr_cfg1) begin
      cfg1 <= WDATA[2:0];
    end
  end
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      cfg3 <= CFG_DEFAULT;
    end else if (apply_default) begin
      cfg3 <= CFG_DEFAULT;
    end else if (wr_cfg3) begin
      cfg3 <= WDATA[2:0];
    end
  end

  // ---------------------------------------------------------------
  // defaults indicator
  // ---------------------------------------------------------------
  // any configuration write drops it, even rewriting the same value;
  // comparing values would hide writes software believes mattered
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      DEFAULTS_LED <= 1'b1;
    end else if (apply_default) begin
      DEFAULTS_LED <= 1'b1;
    end else if (wr_cfg1 || wr_cfg3) begin
      DEFAULTS_LED <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // button event flag
  // ---------------------------------------------------------------
  // a press in the acknowledge cycle wins, so no press is lost
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      BTN_EVENT <= 1'b0;
    end else if (btn_press) begin
      BTN_EVENT <= 1'b1;
    end else if (wr_cmd && WDATA[CMD_BTN_ACK]) begin
      BTN_EVENT <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // event counters on inputs 1 and 3
  // ---------------------------------------------------------------
  logic [CNT_W-1:0] cnt1;
  logic [CNT_W-1:0] cnt3;
  logic hit1;
  logic hit3;
  logic xrst1;
  logic xrst3;
  logic clr1;
  logic clr3;
  // level one means high on every input; an edge field of one selects rising edges
  assign hit1 = cfg1[CFG_EN] && ((cfg1[CFG_EDGE] == EDGE_RISE) ?
    (lvl[0] & ~lvl_d[0]) : (~lvl[0] & lvl_d[0]));
  assign hit3 = cfg3[CFG_EN] && ((cfg3[CFG_EDGE] == EDGE_RISE) ?
    (lvl[2] & ~lvl_d[2]) : (~lvl[2] & lvl_d[2]));
  assign xrst1 = cfg1[CFG_XRST] && lvl[1];
  assign xrst3 = cfg3[CFG_XRST] && lvl[3];
  assign clr1 = wr_cmd && WDATA[CMD_CLR1];
  assign clr3 = wr_cmd && WDATA[CMD_CLR3];
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      cnt1 <= '0;
    end else if (xrst1 || clr1) begin
      cnt1 <= '0;
    end else if (hit1) begin
      cnt1 <= cnt1 + 1'b1;
    end
  end
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      cnt3 <= '0;
    end else if (xrst3 || clr3) begin
      cnt3 <= '0;
    end else if (hit3) begin
      cnt3 <= cnt3 + 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // read data, one cycle after the read strobe
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] next_rdata;
  always_comb begin
    next_rdata = '0;
    unique case (ADDR)
      OFS_INPUTS: next_rdata[3:0] = lvl;
      OFS_CFG1: next_rdata[2:0] = cfg1;
      OFS_CFG3: next_rdata[2:0] = cfg3;
      OFS_CNT1: next_rdata = cnt1;
      OFS_CNT3: next_rdata = cnt3;
      OFS_STATUS: begin
        next_rdata[ST_DEFVALID] = DEFAULTS_LED;
        next_rdata[ST_BTN_EVENT] = BTN_EVENT;
      end
      default: next_rdata = '0;
    endcase
  end
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      RDATA <= '0;
    end else if (RD) begin
      RDATA <= next_rdata;
    end else begin
      RDATA <= '0;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_input_read;
    @(posedge CLK) disable iff (SYS_RST)
      RD && ADDR == OFS_INPUTS |=> RDATA[3:0] == $past(lvl);
  endproperty
  a_input_read: assert property (p_input_read)
    else $error("input read mismatch");

  property p_count_rise;
    @(posedge CLK) disable iff (SYS_RST)
      cfg1[CFG_EN] && cfg1[CFG_EDGE] && lvl[0] && !lvl_d[0] && !xrst1
      && !clr1 |=> cnt1 == $past(cnt1) + 1;
  endproperty
  a_count_rise: assert property (p_count_rise)
    else $error("counter 1 missed edge");

  property p_no_count_off;
    @(posedge CLK) disable iff (SYS_RST)
      !cfg3[CFG_EN] && !clr3 && !xrst3 |=> $stable(cnt3);
  endproperty
  a_no_count_off: assert property (p_no_count_off)
    else $error("counter 3 counted while off");

  property p_cmd_clear;
    @(posedge CLK) disable iff (SYS_RST)
      clr1 |=> cnt1 == '0;
  endproperty
  a_cmd_clear: assert property (p_cmd_clear)
    else $error("counter 1 not cleared");

  property p_xrst_gated;
    @(posedge CLK) disable iff (SYS_RST)
      !cfg3[CFG_XRST] && !clr3 && !hit3 |=> cnt3 == $past(cnt3);
  endproperty
  a_xrst_gated: assert property (p_xrst_gated)
    else $error("counter 3 reset while disabled");

  property p_xrst_hold;
    @(posedge CLK) disable iff (SYS_RST)
      xrst1 [*2] |=> cnt1 == '0;
  endproperty
  a_xrst_hold: assert property (p_xrst_hold)
    else $error("counter 1 not held at zero");

  property p_default_load;
    @(posedge CLK) disable iff (SYS_RST)
      btn_press |=> cfg1 == CFG_DEFAULT && cfg3 == CFG_DEFAULT
      && DEFAULTS_LED;
  endproperty
  a_default_load: assert property (p_default_load)
    else $error("defaults not reloaded");

  property p_led_off;
    @(posedge CLK) disable iff (SYS_RST)
      wr_cfg3 && !apply_default |=> !DEFAULTS_LED;
  endproperty
  a_led_off: assert property (p_led_off)
    else $error("indicator stayed on");

  property p_btn_event;
    @(posedge CLK) disable iff (SYS_RST)
      btn_press |=> BTN_EVENT;
  endproperty
  a_btn_event: assert property (p_btn_event)
    else $error("button event lost");

  property p_cfg_read;
    @(posedge CLK) disable iff (SYS_RST)
      wr_cfg1 && !apply_default ##1 RD && ADDR == OFS_CFG1
      |=> RDATA[2:0] == $past(WDATA[2:0], 2);
  endproperty
  a_cfg_read: assert property (p_cfg_read)
    else $error("config read back wrong");

  property p_count_fall;
    @(posedge CLK) disable iff (SYS_RST)
      cfg3[CFG_EN] && !cfg3[CFG_EDGE] && !lvl[2] && lvl_d[2] && !xrst3
      && !clr3 |=> cnt3 == $past(cnt3) + 1;
  endproperty
  a_count_fall: assert property (p_count_fall)
    else $error("counter 3 missed falling edge");

  property p_idle_cnt1;
    @(posedge CLK) disable iff (SYS_RST)
      !cfg1[CFG_EN] && !clr1 && !xrst1 |=> $stable(cnt1);
  endproperty
  a_idle_cnt1: assert property (p_idle_cnt1)
    else $error("counter 1 counted while off");

  property p_cmd_clear3;
    @(posedge CLK) disable iff (SYS_RST)
      clr3 |=> cnt3 == '0;
  endproperty
  a_cmd_clear3: assert property (p_cmd_clear3)
    else $error("counter 3 not cleared");

  property p_xrst_gated1;
    @(posedge CLK) disable iff (SYS_RST)
      !cfg1[CFG_XRST] && !clr1 && !hit1 |=> cnt1 == $past(cnt1);
  endproperty
  a_xrst_gated1: assert property (p_xrst_gated1)
    else $error("counter 1 reset while disabled");

  property p_xrst_hold3;
    @(posedge CLK) disable iff (SYS_RST)
      xrst3 |=> cnt3 == '0;
  endproperty
  a_xrst_hold3: assert property (p_xrst_hold3)
    else $error("counter 3 not held at zero");

  property p_cmd_default;
    @(posedge CLK) disable iff (SYS_RST)
      wr_cmd && WDATA[CMD_DEFAULT] |=> cfg1 == CFG_DEFAULT
      && cfg3 == CFG_DEFAULT && DEFAULTS_LED;
  endproperty
  a_cmd_default: assert property (p_cmd_default)
    else $error("default command not applied");

  property p_led_off1;
    @(posedge CLK) disable iff (SYS_RST)
      wr_cfg1 && !apply_default |=> !DEFAULTS_LED;
  endproperty
  a_led_off1: assert property (p_led_off1)
    else $error("indicator stayed on after counter 1 setup");

  property p_btn_ack;
    @(posedge CLK) disable iff (SYS_RST)
      wr_cmd && WDATA[CMD_BTN_ACK] && !btn_press |=> !BTN_EVENT;
  endproperty
  a_btn_ack: assert property (p_btn_ack)
    else $error("button event not acknowledged");

  property p_cfg3_read;
    @(posedge CLK) disable iff (SYS_RST)
      wr_cfg3 && !apply_default ##1 RD && ADDR == OFS_CFG3
      |=> RDATA[2:0] == $past(WDATA[2:0], 2);
  endproperty
  a_cfg3_read: assert property (p_cfg3_read)
    else $error("counter 3 config read back wrong");
endmodule : nim_input_event_counter

// ==== nim_in_pkg.sv ====
// shared constants for the logic-level input event counter block
package nim_in_pkg;
  // ---------------------------------------------------------------
  // register map (word offsets on the plain register port)
  // ---------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam logic [3:0] OFS_INPUTS = 4'h0;
  localparam logic [3:0] OFS_CFG1 = 4'h1;
  localparam logic [3:0] OFS_CFG3 = 4'h2;
  localparam logic [3:0] OFS_CNT1 = 4'h3;
  localparam logic [3:0] OFS_CNT3 = 4'h4;
  localparam logic [3:0] OFS_CMD = 4'h5;
  localparam logic [3:0] OFS_STATUS = 4'h6;
  // ---------------------------------------------------------------
  // configuration fields
  // ---------------------------------------------------------------
  localparam int CFG_EN = 0;
  localparam int CFG_EDGE = 1;
  localparam int CFG_XRST = 2;
  localparam logic [2:0] CFG_DEFAULT = 3'h0;
  localparam logic EDGE_RISE = 1'b1;
  // ---------------------------------------------------------------
  // command bits and status bits
  // ---------------------------------------------------------------
  localparam int CMD_CLR1 = 0;
  localparam int CMD_CLR3 = 1;
  localparam int CMD_DEFAULT = 2;
  localparam int CMD_BTN_ACK = 3;
  localparam int ST_DEFVALID = 0;
  localparam int ST_BTN_EVENT = 1;
  localparam int CNT_W = 32;
  localparam int DATA_W = 32;
endpackage : nim_in_pkg

// ==== nim_in_sync.sv ====
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module nim_in_sync (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic d,
  output logic q
);
  logic s1;
  logic s2;
  logic s3;
  // s1 feeds only s2 to keep metastability contained
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
    end
  end
  // change accepted only when stages two and three agree
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      q <= 1'b0;
    end else if (s2 == s3) begin
      q <= s3;
    end
  end
endmodule : nim_in_sync

// ==== nim_src.sv ====
// model of the four external logic-level sources and the default button
`timescale 1ns/1ps
module nim_src (
  input wire logic clk,
  output logic [3:0] nim_in,
  output logic default_btn
);
  // ---------------------------------------------------------------
  // source levels, a one drives the line HI
  // ---------------------------------------------------------------
  initial begin
    nim_in = 4'h0;
    default_btn = 1'b0;
  end
  // levels are held 8 cycles so the input filter always sees them
  task automatic set_in(input int idx, input logic val);
    @(posedge clk);
    nim_in[idx] <= val;
    repeat (8) @(posedge clk);
  endtask : set_in
  task automatic pulse(input int idx);
    set_in(idx, 1'b1);
    set_in(idx, 1'b0);
  endtask : pulse
  task automatic press();
    @(posedge clk);
    default_btn <= 1'b1;
    repeat (8) @(posedge clk);
    default_btn <= 1'b0;
    repeat (8) @(posedge clk);
  endtask : press
endmodule : nim_src

// ==== nim_input_event_counter_tb_top.sv ====
// self-checking bench for the input event counter block
`timescale 1ns/1ps
module nim_input_event_counter_tb_top;
  import nim_in_pkg::*;
  typedef struct packed {
    logic [3:0] lvl;
    logic [DATA_W-1:0] exp;
  } row_t;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] nim_in;
  logic default_btn;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [DATA_W-1:0] rdata;
  logic defaults_led;
  logic btn_event;
  int n_mismatch = 0;
  int n_checks = 0;
  row_t rows [6] = '{'{4'h1, 32'h1}, '{4'h2, 32'h2}, '{4'h4, 32'h4},
    '{4'h8, 32'h8}, '{4'ha, 32'ha}, '{4'h5, 32'h5}};
  always #5 clk = ~clk;
  nim_input_event_counter u_nim_input_event_counter (
    .CLK(clk), .SYS_RST(sys_rst), .NIM_IN(nim_in),
    .DEFAULT_BTN(default_btn), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .DEFAULTS_LED(defaults_led),
    .BTN_EVENT(btn_event)
  );
  nim_src u_nim_src (.clk(clk), .nim_in(nim_in), .default_btn(default_btn));
  // ---------------------------------------------------------------
  // checks and bus tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [DATA_W-1:0] got,
    input logic [DATA_W-1:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_bit
  task automatic wr_reg(input logic [ADDR_W-1:0] a,
    input logic [DATA_W-1:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [ADDR_W-1:0] a,
    input logic [DATA_W-1:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask : rd_chk
  // write then read with no gap, which the bus allows
  task automatic wr_rd_chk(input logic [ADDR_W-1:0] a,
    input logic [DATA_W-1:0] d, input logic [DATA_W-1:0] e);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask : wr_rd_chk
  task automatic test_done();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done
  initial begin
    repeat (10000) @(posedge clk);
    n_mismatch++;
    test_done();
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    rd_chk(OFS_CFG1, 32'h0);
    rd_chk(OFS_STATUS, 32'h1);
    chk_bit(btn_event, 1'b0);
    foreach (rows[i]) begin
      for (int j = 0; j < 4; j++) u_nim_src.set_in(j, rows[i].lvl[j]);
      rd_chk(OFS_INPUTS, rows[i].exp);
    end
    for (int j = 0; j < 4; j++) u_nim_src.set_in(j, 1'b0);
    rd_chk(OFS_CNT1, 32'h0);
    wr_reg(OFS_CFG1, 32'h3);
    rd_chk(OFS_CFG1, 32'h3);
    chk_bit(defaults_led, 1'b0);
    repeat (3) u_nim_src.pulse(0);
    u_nim_src.set_in(0, 1'b1);
    rd_chk(OFS_CNT1, 32'h4);
    wr_reg(OFS_CFG3, 32'h1);
    u_nim_src.set_in(2, 1'b1);
    rd_chk(OFS_CNT3, 32'h0);
    u_nim_src.set_in(2, 1'b0);
    rd_chk(OFS_CNT3, 32'h1);
    wr_reg(OFS_CMD, 32'h1 << CMD_CLR1);
    rd_chk(OFS_CNT1, 32'h0);
    // reset input high but its enable still off: counting goes on
    u_nim_src.set_in(1, 1'b1);
    u_nim_src.set_in(0, 1'b0);
    u_nim_src.set_in(0, 1'b1);
    rd_chk(OFS_CNT1, 32'h1);
    wr_reg(OFS_CFG1, 32'h7);
    rd_chk(OFS_CNT1, 32'h0);
    u_nim_src.pulse(0);
    rd_chk(OFS_CNT1, 32'h0);
    u_nim_src.set_in(1, 1'b0);
    u_nim_src.pulse(0);
    rd_chk(OFS_CNT1, 32'h1);
    wr_reg(OFS_CMD, 32'h1 << CMD_DEFAULT);
    repeat (2) @(posedge clk);
    #1;
    chk_bit(defaults_led, 1'b1);
    rd_chk(OFS_CFG1, 32'h0);
    wr_reg(OFS_CFG3, 32'h5);
    u_nim_src.set_in(3, 1'b1);
    rd_chk(OFS_CNT3, 32'h0);
    u_nim_src.set_in(3, 1'b0);
    chk_bit(defaults_led, 1'b0);
    u_nim_src.press();
    rd_chk(OFS_CFG3, 32'h0);
    rd_chk(OFS_STATUS, 32'h3);
    chk_bit(btn_event, 1'b1);
    wr_reg(OFS_CMD, 32'h1 << CMD_BTN_ACK);
    repeat (2) @(posedge clk);
    #1;
    chk_bit(btn_event, 1'b0);
    // unmapped place: write ignored, read gives zero
    wr_reg(4'hf, 32'hffffffff);
    rd_chk(4'hf, 32'h0);
    rd_chk(OFS_STATUS, 32'h1);
    @(posedge clk);
    #1;
    chk(rdata, 32'h0);
    // falling edges on input 1, rising on input 3, then clear counter 3
    wr_rd_chk(OFS_CFG1, 32'h1, 32'h1);
    u_nim_src.pulse(0);
    rd_chk(OFS_CNT1, 32'h2);
    wr_rd_chk(OFS_CFG3, 32'h3, 32'h3);
    u_nim_src.pulse(2);
    rd_chk(OFS_CNT3, 32'h1);
    wr_reg(OFS_CMD, 32'h1 << CMD_CLR3);
    rd_chk(OFS_CNT3, 32'h0);
    rd_chk(OFS_CNT1, 32'h2);
    // reset in mid-run restores the defaults and clears the counters
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rd_chk(OFS_CNT1, 32'h0);
    rd_chk(OFS_CFG3, 32'h0);
    rd_chk(OFS_STATUS, 32'h1);
    test_done();
  end
endmodule : nim_input_event_counter_tb_top
